/* File: rtl/msd_port.sv */
// Processor register port: mode, status, drawing pointers, pixel data.
// Assumes pins come from the processor bus, blanking from raster logic
// on the core clock, and DRAM cycles from an external controller.
`timescale 1ns/10ps
`default_nettype none
`include "msd_defines.svh"

module msd_port (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_io_select_n,
  input  wire logic       i_rw,
  input  wire logic [1:0] i_reg_sel,
  input  wire logic [7:0] i_ad,
  output logic      [7:0] o_ad,
  output logic            o_ad_oe,
  input  wire logic       i_h_blank,
  input  wire logic       i_h_sync_blank,
  input  wire logic       i_v_blank,
  input  wire logic       i_v_sync_blank,
  output msd_pkg::msd_mode_t o_mode_field,
  output logic            o_submode,
  output logic      [2:0] o_page,
  output msd_pkg::msd_page_kind_t o_page_kind,
  output logic            o_fetch_row_ok,
  output logic            o_dram_req,
  output logic            o_dram_we,
  output logic      [7:0] o_dram_row,
  output logic      [6:0] o_dram_col,
  output logic      [7:0] o_dram_wdata,
  output logic            o_row_strobe_low_bank,
  output logic            o_row_strobe_high_bank,
  input  wire logic       i_dram_ack,
  input  wire logic [7:0] i_dram_rdata
);
  import msd_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------

  logic [11:0] pins_s;
  logic        sel_n_s;
  logic        rw_s;
  logic [1:0]  rsel_s;
  logic [7:0]  wdata_s;

  // Select, direction, register select and bus data
  msd_sync #(
    .WIDTH (12)
  ) u_pin_sync (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_async     ({i_io_select_n, i_rw, i_reg_sel, i_ad}),
    .i_reset_val ({12{1'b1}}),
    .o_sync      (pins_s)
  );

  assign sel_n_s = pins_s[11];
  assign rw_s    = pins_s[10];
  assign rsel_s  = pins_s[9:8];
  assign wdata_s = pins_s[7:0];

  // ----------------------------------------------------------------
  // Access detection
  // ----------------------------------------------------------------

  logic sel_prev_n_q, sel_prev_n_d;
  logic access;
  logic acc_wr;
  logic acc_rd;

  // Falling edge of the synchronised select starts one access
  always_comb begin
    sel_prev_n_d = sel_n_s;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sel_prev_n_q <= 1'b1;
    end else begin
      sel_prev_n_q <= sel_prev_n_d;
    end
  end

  assign access = sel_prev_n_q & ~sel_n_s;
  assign acc_wr = access & ~rw_s;
  assign acc_rd = access & rw_s;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------

  logic [3:0] mode_q, mode_d;
  logic [2:0] page_q, page_d;
  logic [7:0] col_q, col_d;
  logic [7:0] row_q, row_d;
  logic [7:0] rd_q, rd_d;
  msd_mode_t  mode;
  logic       draw_mode;
  logic       byte_mode;
  logic       sel_mode;
  logic       sel_col;
  logic       sel_row;
  logic       sel_pix;
  logic       h_blank;
  logic       v_blank;
  logic [7:0] status;
  logic       dram_busy;
  logic       dram_done;
  logic       dram_start;
  logic [7:0] dram_rdata;
  logic       pend_we_q, pend_we_d;

  assign mode      = msd_mode_t'(mode_q[`MSD_MODE_MSB:`MSD_MODE_LSB]);
  assign draw_mode = (mode == MSD_MODE_DRAW);
  assign byte_mode = mode_q[`MSD_SUBMODE_BIT];
  assign sel_mode  = (rsel_s == `MSD_SEL_MODE_STATUS);
  assign sel_col   = (rsel_s == `MSD_SEL_COLUMN_PTR) & draw_mode;
  assign sel_row   = (rsel_s == `MSD_SEL_ROW_PTR) & draw_mode;
  assign sel_pix   = (rsel_s == `MSD_SEL_PIXEL_DATA);

  // Blanking spans the whole non-pixel time, sync periods included
  assign h_blank = i_h_blank | i_h_sync_blank;
  assign v_blank = i_v_blank | i_v_sync_blank;

  // Status word, blanking bits active low
  always_comb begin
    status = 8'h00;
    status[`MSD_SR_VBLANK_BIT] = ~v_blank;
    status[`MSD_SR_HBLANK_BIT] = ~h_blank;
    status[`MSD_SR_MODE_MSB:`MSD_SR_MODE_LSB] =
      mode_q[`MSD_MODE_MSB:`MSD_MODE_LSB];
    status[`MSD_SR_PAGE_MSB:`MSD_SR_PAGE_LSB] = page_q;
  end

  // Pixel access starts only in drawing mode with the sequencer free
  assign dram_start = access & sel_pix & draw_mode & ~dram_busy;

  // ----------------------------------------------------------------
  // Register file next values
  // ----------------------------------------------------------------

  always_comb begin
    mode_d    = mode_q;
    page_d    = page_q;
    col_d     = col_q;
    row_d     = row_q;
    rd_d      = rd_q;
    pend_we_d = pend_we_q;
    // Mode register written regardless of stored mode
    if (acc_wr && sel_mode) begin
      mode_d = wdata_s[3:0];
    end
    // Status read sampled at the access
    if (acc_rd && sel_mode) begin
      rd_d = status;
    end
    // Drawing pointers, full 0 to 255 range
    if (acc_wr && sel_col) begin
      col_d = wdata_s;
    end
    if (acc_wr && sel_row) begin
      row_d = wdata_s;
    end
    if (acc_rd && sel_col) begin
      rd_d = col_q;
    end
    if (acc_rd && sel_row) begin
      rd_d = row_q;
    end
    // Page register written in page mode; code 7 inert elsewhere
    if (acc_wr && sel_pix && mode == MSD_MODE_PAGE) begin
      page_d = wdata_s[2:0];
    end
    // Non-drawing reads above select 0 return idle data
    if (acc_rd && !sel_mode && !draw_mode) begin
      rd_d = `MSD_IDLE_READ;
    end
    if (dram_start) begin
      pend_we_d = ~rw_s;
    end
    // Finished pixel access: return read data, or advance column after a byte write
    if (dram_done) begin
      if (!pend_we_q) begin
        rd_d = dram_rdata;
      end else if (byte_mode) begin
        col_d = col_q + `MSD_PTR_STEP;
      end
    end
  end

  // Register file, mode bits all ones out of reset
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q    <= `MSD_MODE_RESET;
      page_q    <= `MSD_PAGE_RESET;
      col_q     <= `MSD_PTR_RESET;
      row_q     <= `MSD_PTR_RESET;
      rd_q      <= `MSD_IDLE_READ;
      pend_we_q <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      page_q    <= page_d;
      col_q     <= col_d;
      row_q     <= row_d;
      rd_q      <= rd_d;
      pend_we_q <= pend_we_d;
    end
  end

  // ----------------------------------------------------------------
  // DRAM access sequencer
  // ----------------------------------------------------------------

  msd_dram_port u_dram (
    .i_core_clk             (i_core_clk),
    .i_rst_n                (i_rst_n),
    .i_start                (dram_start),
    .i_write                (~rw_s),
    .i_byte_mode            (byte_mode),
    .i_column               (col_q),
    .i_row                  (row_q),
    .i_wdata                (wdata_s),
    .i_dram_ack             (i_dram_ack),
    .i_dram_rdata           (i_dram_rdata),
    .o_busy                 (dram_busy),
    .o_done                 (dram_done),
    .o_rdata                (dram_rdata),
    .o_dram_req             (o_dram_req),
    .o_dram_we              (o_dram_we),
    .o_dram_row             (o_dram_row),
    .o_dram_col             (o_dram_col),
    .o_dram_wdata           (o_dram_wdata),
    .o_row_strobe_low_bank  (o_row_strobe_low_bank),
    .o_row_strobe_high_bank (o_row_strobe_high_bank)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // Bus driven while selected for a read
  assign o_ad         = rd_q;
  assign o_ad_oe      = ~sel_n_s & rw_s;
  assign o_mode_field = mode;
  assign o_submode    = byte_mode;
  assign o_page       = page_q;
  assign o_page_kind  = msd_page_kind(page_q);
  // Rows above 209 lie past offset 8FF of the fourth page
  assign o_fetch_row_ok = (row_q <= `MSD_LAST_FETCH_ROW);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_mode_write_load: assert property (
    acc_wr && sel_mode |=> mode_q == $past(wdata_s[3:0]))
    else $error("mode write not stored");

  a_mode_hold: assert property (
    !(acc_wr && sel_mode) |=> $stable(mode_q))
    else $error("mode changed without a mode write");

  a_status_read: assert property (
    acc_rd && sel_mode |=> o_ad == {~$past(v_blank), ~$past(h_blank),
      $past(mode_q[2:0]), $past(page_q)})
    else $error("status read value wrong");

  a_blank_low: assert property (
    acc_rd && sel_mode && i_v_sync_blank |=> !o_ad[7])
    else $error("vertical blanking not reported low");

  a_column_step: assert property (
    dram_done && pend_we_q && byte_mode |=>
      col_q == 8'($past(col_q) + 8'h02))
    else $error("byte write did not step column by two");

  a_nibble_keep: assert property (
    dram_done && !byte_mode |=> $stable(col_q) && $stable(row_q))
    else $error("nibble access moved a pointer");

  a_page_load: assert property (
    acc_wr && sel_pix && mode == MSD_MODE_PAGE |=>
      page_q == $past(wdata_s[2:0]))
    else $error("page write not stored");

  a_unused_inert: assert property (
    access && mode == MSD_MODE_UNUSED && !sel_mode |=>
      $stable(col_q) && $stable(row_q) && $stable(page_q))
    else $error("unused mode changed state");

  a_no_pix_outside: assert property (
    access && sel_pix && !draw_mode && !dram_busy |=> !o_dram_req)
    else $error("pixel access outside drawing mode");

  a_pix_read_back: assert property (
    dram_done && !pend_we_q |=> o_ad == $past(dram_rdata))
    else $error("pixel read data not returned");

endmodule // msd_port

`default_nettype wire

/* File: pkg/msd_defines.svh */
// Constants of the mode, status and drawing pointer register port.
// Included by the package and by every design file that needs a figure.
`ifndef MSD_DEFINES_SVH
`define MSD_DEFINES_SVH

// ----------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------
`define MSD_SEL_MODE_STATUS 2'h0
`define MSD_SEL_COLUMN_PTR  2'h1
`define MSD_SEL_ROW_PTR     2'h2
`define MSD_SEL_PIXEL_DATA  2'h3

// ----------------------------------------------------------------
// Mode register fields and reset value
// ----------------------------------------------------------------
`define MSD_MODE_RESET      4'hf
`define MSD_SUBMODE_BIT     3
`define MSD_MODE_MSB        2
`define MSD_MODE_LSB        0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define MSD_SR_VBLANK_BIT   7
`define MSD_SR_HBLANK_BIT   6
`define MSD_SR_MODE_MSB     5
`define MSD_SR_MODE_LSB     3
`define MSD_SR_PAGE_MSB     2
`define MSD_SR_PAGE_LSB     0

// ----------------------------------------------------------------
// Pointer, page and fetch constants
// ----------------------------------------------------------------
`define MSD_PTR_RESET       8'h00
`define MSD_PAGE_RESET      3'h7
`define MSD_PTR_STEP        8'h02
`define MSD_LAST_FETCH_ROW  8'hd1
`define MSD_PAGE3_LAST_OFS  13'h08ff
`define MSD_IDLE_READ       8'h00

`endif

/* File: pkg/msd_pkg.sv */
// Types shared by the register port and its DRAM access sequencer.
// Assumes msd_defines.svh is reachable on the include path.
`include "msd_defines.svh"

package msd_pkg;

  // Operating modes held in the mode field
  typedef enum logic [2:0] {
    MSD_MODE_DRAW    = 3'h0,
    MSD_MODE_TBL_ADR = 3'h1,
    MSD_MODE_TBL_DAT = 3'h2,
    MSD_MODE_SWITCH  = 3'h3,
    MSD_MODE_SCROLL  = 3'h4,
    MSD_MODE_TTX_PTR = 3'h5,
    MSD_MODE_PAGE    = 3'h6,
    MSD_MODE_UNUSED  = 3'h7
  } msd_mode_t;

  // DRAM sequencer states, Gray along idle, request, done
  typedef enum logic [1:0] {
    MSD_DS_IDLE = 2'b00,
    MSD_DS_REQ  = 2'b01,
    MSD_DS_DONE = 2'b11
  } msd_dstate_t;

  // Kind of DRAM page that a page code selects
  typedef enum logic [1:0] {
    MSD_PG_VIDEO   = 2'h0,
    MSD_PG_SPLIT   = 2'h1,
    MSD_PG_PROGRAM = 2'h2,
    MSD_PG_NONE    = 2'h3
  } msd_page_kind_t;

  // Decode a page code into its kind
  function automatic msd_page_kind_t msd_page_kind(input logic [2:0] code);
    case (code)
      3'h0, 3'h1, 3'h2: msd_page_kind = MSD_PG_VIDEO;
      3'h3:             msd_page_kind = MSD_PG_SPLIT;
      3'h4:             msd_page_kind = MSD_PG_PROGRAM;
      default:          msd_page_kind = MSD_PG_NONE;
    endcase
  endfunction

endpackage

/* File: rtl/msd_sync.sv */
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes the pins are quasi-static across the bus cycle.
`timescale 1ns/10ps
`default_nettype none

module msd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  input  wire logic [WIDTH-1:0] i_reset_val,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

  // Reset value input ignored; both stages always reset to all ones
  logic unused_reset_val;
  assign unused_reset_val = ^i_reset_val;

endmodule // msd_sync

`default_nettype wire

/* File: rtl/msd_dram_port.sv */
// Sequencer for one processor pixel access to video DRAM.
// Assumes the DRAM controller answers each request with a one-cycle ack.
`timescale 1ns/10ps
`default_nettype none
`include "msd_defines.svh"

module msd_dram_port (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic       i_write,
  input  wire logic       i_byte_mode,
  input  wire logic [7:0] i_column,
  input  wire logic [7:0] i_row,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_dram_ack,
  input  wire logic [7:0] i_dram_rdata,
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_rdata,
  output logic            o_dram_req,
  output logic            o_dram_we,
  output logic [7:0]      o_dram_row,
  output logic [6:0]      o_dram_col,
  output logic [7:0]      o_dram_wdata,
  output logic            o_row_strobe_low_bank,
  output logic            o_row_strobe_high_bank
);
  import msd_pkg::*;

  msd_dstate_t state_q, state_d;
  logic        we_q, we_d;
  logic        lo_q, lo_d;
  logic        hi_q, hi_d;
  logic        byte_q, byte_d;
  logic [7:0]  row_q, row_d;
  logic [6:0]  col_q, col_d;
  logic [7:0]  wd_q, wd_d;
  logic [7:0]  rd_q, rd_d;

  // Next state: latch the access, wait for ack, report done
  always_comb begin
    state_d = state_q;
    we_d    = we_q;
    lo_d    = lo_q;
    hi_d    = hi_q;
    byte_d  = byte_q;
    row_d   = row_q;
    col_d   = col_q;
    wd_d    = wd_q;
    rd_d    = rd_q;
    unique case (state_q)
      MSD_DS_IDLE: begin
        if (i_start) begin
          state_d = MSD_DS_REQ;
          we_d    = i_write;
          byte_d  = i_byte_mode;
          row_d   = i_row;
          col_d   = i_column[7:1];
          wd_d    = i_wdata;
          lo_d    = i_byte_mode | ~i_column[0];
          hi_d    = i_byte_mode | i_column[0];
        end
      end
      MSD_DS_REQ: begin
        if (i_dram_ack) begin
          state_d = MSD_DS_DONE;
          // Nibble reads echo the chosen nibble on both halves
          if (byte_q) begin
            rd_d = i_dram_rdata;
          end else if (hi_q) begin
            rd_d = {2{i_dram_rdata[7:4]}};
          end else begin
            rd_d = {2{i_dram_rdata[3:0]}};
          end
        end
      end
      MSD_DS_DONE: begin
        state_d = MSD_DS_IDLE;
      end
      default: begin
        state_d = MSD_DS_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= MSD_DS_IDLE;
      we_q    <= 1'b0;
      lo_q    <= 1'b0;
      hi_q    <= 1'b0;
      byte_q  <= 1'b0;
      row_q   <= `MSD_PTR_RESET;
      col_q   <= 7'h00;
      wd_q    <= 8'h00;
      rd_q    <= 8'h00;
    end else begin
      state_q <= state_d;
      we_q    <= we_d;
      lo_q    <= lo_d;
      hi_q    <= hi_d;
      byte_q  <= byte_d;
      row_q   <= row_d;
      col_q   <= col_d;
      wd_q    <= wd_d;
      rd_q    <= rd_d;
    end
  end

  // Outputs toward DRAM controller and register port
  assign o_busy                 = (state_q != MSD_DS_IDLE);
  assign o_done                 = (state_q == MSD_DS_DONE);
  assign o_rdata                = rd_q;
  assign o_dram_req             = (state_q == MSD_DS_REQ);
  assign o_dram_we              = we_q;
  assign o_dram_row             = row_q;
  assign o_dram_col             = col_q;
  assign o_dram_wdata           = wd_q;
  assign o_row_strobe_low_bank  = o_dram_req & lo_q;
  assign o_row_strobe_high_bank = o_dram_req & hi_q;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  a_nibble_one_bank: assert property (
    o_dram_req && !byte_q |->
      (o_row_strobe_low_bank != o_row_strobe_high_bank))
    else $error("nibble access strobed both or no banks");

  a_nibble_bank_pick: assert property (
    state_q == MSD_DS_IDLE && i_start && !i_byte_mode |=>
      o_row_strobe_low_bank == !$past(i_column[0]))
    else $error("nibble bank does not follow column lsb");

endmodule // msd_dram_port

`default_nettype wire

/* File: test/msd_dram_model.sv */
// DRAM controller stand-in for the pixel data path.
// Assumes one request at a time, held until the acknowledge edge.
`timescale 1ns/10ps
`default_nettype none

module msd_dram_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_row,
  input  wire logic [6:0] i_col,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_lo,
  input  wire logic       i_hi,
  output logic            o_ack,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [logic [14:0]];
  logic [7:0] cur;
  int         wait_q = 0;

  initial begin
    o_ack = 1'b0;
    o_rdata = 8'h00;
  end

  // Ack after 0 to 3 idle cycles; idle data toggles so it is never trusted
  always @(posedge i_core_clk) begin
    cur = mem.exists({i_row, i_col}) ? mem[{i_row, i_col}] : 8'h00;
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack && wait_q > 0) begin
      wait_q <= wait_q - 1;
    end else if (i_req && !o_ack) begin
      o_ack <= 1'b1;
      o_rdata <= cur;
      wait_q <= $urandom_range(0, 3);
      if (i_we && i_lo) cur[3:0] = i_wdata[3:0];
      if (i_we && i_hi) cur[7:4] = i_wdata[7:4];
      if (i_we) mem[{i_row, i_col}] = cur;
    end
  end
endmodule // msd_dram_model
`default_nettype wire

/* File: test/mode_status_draw_pointer_port_test.sv */
// Self-checking bench of the register port against a behavioural model.
// Assumes msd_pkg and the DRAM model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end

module mode_status_draw_pointer_port_test;
  import msd_pkg::*;
  logic           clk, rst_n, io_n, rw, hb, hsb, vb, vsb, oe, sub, fok;
  logic           req, we, lo, hi, ack;
  logic [1:0]     rs;
  logic [2:0]     page;
  logic [3:0]     n;
  logic [6:0]     dcol;
  logic [7:0]     ad, o_ad, drow, wd, rd;
  msd_mode_t      mf;
  msd_page_kind_t pk;
  int             errors, comparisons, m, s, col, row, pg;
  int             bm [int];

  msd_port u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_io_select_n(io_n),
    .i_rw(rw), .i_reg_sel(rs), .i_ad(ad), .o_ad(o_ad), .o_ad_oe(oe),
    .i_h_blank(hb), .i_h_sync_blank(hsb), .i_v_blank(vb),
    .i_v_sync_blank(vsb), .o_mode_field(mf), .o_submode(sub),
    .o_page(page), .o_page_kind(pk), .o_fetch_row_ok(fok),
    .o_dram_req(req), .o_dram_we(we), .o_dram_row(drow), .o_dram_col(dcol),
    .o_dram_wdata(wd), .o_row_strobe_low_bank(lo),
    .o_row_strobe_high_bank(hi), .i_dram_ack(ack), .i_dram_rdata(rd));

  msd_dram_model u_dram (.i_core_clk(clk), .i_req(req), .i_we(we),
    .i_row(drow), .i_col(dcol), .i_wdata(wd), .i_lo(lo), .i_hi(hi),
    .o_ack(ack), .o_rdata(rd));

  // ------------------------------------------------------------
  // Clock, watchdog and verdict
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    #400000;
    errors++;
    finish_test();
  end

  task automatic finish_test();
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // One register access; the model predicts, then the port is compared
  task automatic acc(input logic r, input logic [1:0] a,
                     input logic [7:0] d);
    logic [7:0] e;
    int         k, v;
    e = 8'h00;
    k = row * 128 + col / 2;
    v = bm.exists(k) ? bm[k] : 0;
    @(negedge clk);
    {hb, hsb, vb, vsb} = 4'($urandom);
    io_n = 1'b1;
    rw = r;
    rs = a;
    ad = d;
    if (a == 0 && r) e = {~(vb | vsb), ~(hb | hsb), 3'(m), 3'(pg)};
    else if (a == 0) begin m = d[2:0]; s = d[3]; end
    else if (m == 0 && a < 3 && r) e = 8'(a == 1 ? col : row);
    else if (m == 0 && a == 1) col = d;
    else if (m == 0 && a == 2) row = d;
    else if (m == 0 && r)
      e = s ? 8'(v) : 8'((col % 2 ? v / 16 : v % 16) * 17);
    else if (m == 0 && s) begin bm[k] = d; col = (col + 2) % 256; end
    else if (m == 0)
      bm[k] = col % 2 ? v % 16 + (d & 8'hf0) : (v & 8'hf0) + d % 16;
    else if (m == 6 && a == 3 && !r) pg = d[2:0];
    repeat (4) @(negedge clk);
    `CHK(oe, 1'b0)
    io_n = 1'b0;
    repeat (16) @(negedge clk);
    if (r) `CHK(o_ad, e)
    `CHK({mf, sub, page}, {3'(m), 1'(s), 3'(pg)})
    `CHK({oe, fok}, {r, 1'(row <= 209)})
    io_n = 1'b1;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(17068));
    {rst_n, rw, rs, ad, hb, hsb, vb, vsb, n} = '0;
    io_n = 1'b1;
    {errors, comparisons, col, row} = '0;
    {m, s, pg} = {32'd7, 32'd1, 32'd7};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    acc(1, 0, 0);
    // Every mode code, with junk in the ignored upper bits
    for (int c = 0; c < 8; c++) begin
      acc(0, 0, {4'($urandom), 1'(c % 2), 3'(c)});
      acc(1, 0, 0);
      if (c > 0 && c != 6) begin
        acc(0, 1, 8'h5a);
        acc(1, 1, 0);
      end
    end
    // Page codes 0 to 4 through mode 6
    acc(0, 0, 8'h06);
    for (int p = 0; p < 5; p++) begin
      acc(0, 3, {5'($urandom), 3'(p)});
      `CHK(pk, msd_page_kind_t'(p < 3 ? 0 : p - 2))
    end
    acc(0, 3, 8'h00);
    // Byte writes across the column wrap, then row limit boundary
    acc(0, 0, 8'h08);
    acc(0, 1, 8'hfe);
    acc(0, 3, 8'h3c);
    acc(0, 3, 8'hc3);
    acc(1, 1, 0);
    acc(0, 1, 8'hfe);
    acc(1, 3, 0);
    acc(0, 2, 8'hd1);
    acc(0, 2, 8'hd2);
    // Random mix of pointer, pixel and status traffic in mode 0
    for (int i = 0; i < 400; i++) begin
      n = 4'($urandom);
      case ($urandom_range(0, 6))
        0: acc(0, 0, {4'($urandom), 1'($urandom), 3'h0});
        1: acc(1'($urandom), 1, 8'($urandom));
        2: acc(1'($urandom), 2, 8'($urandom));
        3, 4: acc(0, 3, s ? 8'($urandom) : {n, n});
        5: acc(1, 3, 0);
        default: acc(1, 0, 0);
      endcase
    end
    // Reset again mid-run: mode, page and pointers return to reset values
    rst_n = 1'b0;
    {m, s, pg, col, row} = {32'd7, 32'd1, 32'd7, 32'd0, 32'd0};
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    acc(1, 0, 0);
    `CHK(pk, msd_page_kind_t'(3))
    acc(0, 0, 8'h00);
    acc(1, 1, 0);
    finish_test();
  end
endmodule // mode_status_draw_pointer_port_test
`default_nettype wire
